//--- src/dcir_addr_decode.sv
// dcir_addr_decode: maps a byte address to a register selector.
// assumes strobes are one cycle and never both high at once.
`default_nettype none

module dcir_addr_decode #(
    parameter int ADDR_W = dcir_pkg::ADDR_W
) (
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output dcir_pkg::dcir_reg_t    wr_sel,
    output dcir_pkg::dcir_reg_t    rd_sel
);

    function automatic dcir_pkg::dcir_reg_t reg_of(
        input logic [ADDR_W-1:0] a
    );
        dcir_pkg::dcir_reg_t r;
        r = dcir_pkg::REG_NONE;
        // whole address compared, so any high bit set lands on no register
        unique case (a)
            ADDR_W'(dcir_pkg::OFS_RAW):      r = dcir_pkg::REG_RAW;
            ADDR_W'(dcir_pkg::OFS_MASKED):   r = dcir_pkg::REG_MASKED;
            ADDR_W'(dcir_pkg::OFS_EN_SET):   r = dcir_pkg::REG_EN_SET;
            ADDR_W'(dcir_pkg::OFS_EN_CLR):   r = dcir_pkg::REG_EN_CLR;
            ADDR_W'(dcir_pkg::OFS_RX_CTL):   r = dcir_pkg::REG_RX_CTL;
            ADDR_W'(dcir_pkg::OFS_IRQ_STAT): r = dcir_pkg::REG_IRQ_STAT;
            ADDR_W'(dcir_pkg::OFS_IRQ_MASK): r = dcir_pkg::REG_IRQ_MASK;
            default:                         r = dcir_pkg::REG_NONE;
        endcase
        return r;
    endfunction

    assign wr_sel = reg_wr ? reg_of(reg_addr) : dcir_pkg::REG_NONE;
    assign rd_sel = reg_rd ? reg_of(reg_addr) : dcir_pkg::REG_NONE;

endmodule

`default_nettype wire

//--- src/dcir_flag_bank.sv
// dcir_flag_bank: a row of flags with per-bit set and clear.
// assumes set and clr are synchronous to core_clk.
`default_nettype none

module dcir_flag_bank #(
    parameter int         W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    dcir_flag_if.bank   flg
);

    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // set wins over a clear in the same cycle so no event is lost
    assign nxt_q = (q_ff & ~flg.clr) | flg.set;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q_ff <= RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign flg.q = q_ff;

endmodule

`default_nettype wire

//--- src/dcir_flag_if.sv
// dcir_flag_if: set, clear and value of one bank of flags.
// assumes the owner of set and clr runs on the same clock as the bank.
`default_nettype none

interface dcir_flag_if #(
    parameter int W = 4
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;

    modport bank (
        input  set,
        input  clr,
        output q
    );

    modport ctrl (
        output set,
        output clr,
        input  q
    );
endinterface

`default_nettype wire

//--- src/dcir_pkg.sv
// dcir_pkg: offsets, reset values and register selectors for the dma
// completion interrupt register block.
// assumes a 32-bit register port with byte addresses in reg_addr.
`default_nettype none

package dcir_pkg;

    localparam int          CHANNELS      = 4;
    localparam int          IRQ_BITS      = 2 * CHANNELS;
    localparam int          ADDR_W        = 8;

    // byte offsets, one aligned word each
    localparam logic [7:0]  OFS_RAW       = 8'h00;
    localparam logic [7:0]  OFS_MASKED    = 8'h04;
    localparam logic [7:0]  OFS_EN_SET    = 8'h08;
    localparam logic [7:0]  OFS_EN_CLR    = 8'h0c;
    localparam logic [7:0]  OFS_RX_CTL    = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;

    // field positions
    localparam int          RX_ON_BIT     = 0;
    localparam int          IRQ_DONE_LSB  = 0;
    localparam int          IRQ_OVR_LSB   = CHANNELS;

    // values after reset
    localparam logic [3:0]  RST_RAW       = 4'h0;
    localparam logic [3:0]  RST_EN        = 4'h0;
    localparam logic        RST_RX_ON     = 1'b0;
    localparam logic [7:0]  RST_IRQ_STAT  = 8'h00;
    localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;
    localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

    typedef enum logic [2:0] {
        REG_RAW,
        REG_MASKED,
        REG_EN_SET,
        REG_EN_CLR,
        REG_RX_CTL,
        REG_IRQ_STAT,
        REG_IRQ_MASK,
        REG_NONE
    } dcir_reg_t;

endpackage

`default_nettype wire

//--- src/dcir_top.sv
// dcir_top: completion flags, interrupt enables and receive dma enable
// for the packet dma, behind a plain register port.
// assumes tx_done_pulse and tx_done_ack come from dma logic on core_clk.
//
// Summary of operation
// - one high-active completion flag per channel 3..0 is set when a packet on that channel finishes on the high-priority queue.
// - the raw completion flags are read-only, read zero after reset, and the upper bits of that word read zero.
// - four high-active interrupt enables, one per channel and paired with that channel's flag, all reset to zero.
// - writing a one to a bit of the enable-clear word clears that channel's enable, zeros leave it alone.
// - receive dma runs only while bit 0 of its control word is one; read-write, zero after reset.
// - the masked completion status of each channel is the raw flag and-ed with its enable.
`default_nettype none

module dcir_top #(
    parameter int CHANNELS = dcir_pkg::CHANNELS,
    parameter int ADDR_W   = dcir_pkg::ADDR_W
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    input  wire logic [CHANNELS-1:0] tx_done_pulse,
    input  wire logic [CHANNELS-1:0] tx_done_ack,
    output logic      [CHANNELS-1:0] tx_done_masked,
    output logic                     rx_dma_on,
    output logic                     irq
);

    localparam int IRQ_BITS = 2 * CHANNELS;

    dcir_pkg::dcir_reg_t wr_sel;
    dcir_pkg::dcir_reg_t rd_sel;

    dcir_flag_if #(.W(CHANNELS)) raw_if ();
    dcir_flag_if #(.W(CHANNELS)) en_if ();
    dcir_flag_if #(.W(IRQ_BITS)) ist_if ();

    logic                rx_on_ff;
    logic [IRQ_BITS-1:0] irq_mask_ff;
    logic [CHANNELS-1:0] masked;
    logic [CHANNELS-1:0] masked_ff;
    logic [CHANNELS-1:0] overrun;
    logic [31:0]         rd_value;
    logic [31:0]         nxt_rdata;
    logic [31:0]         rdata_ff;

    dcir_addr_decode #(
        .ADDR_W (ADDR_W)
    ) u_decode (
        .reg_addr (reg_addr),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .wr_sel   (wr_sel),
        .rd_sel   (rd_sel)
    );

    // raw completion flags: set by the dma, cleared only by the dma's ack
    // since software has no write path to them
    dcir_flag_bank #(
        .W   (CHANNELS),
        .RST (CHANNELS'(dcir_pkg::RST_RAW))
    ) u_raw (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .flg      (raw_if.bank)
    );

    assign raw_if.set = tx_done_pulse;
    assign raw_if.clr = tx_done_ack;

    // interrupt enables, touched only through the set and clear words
    dcir_flag_bank #(
        .W   (CHANNELS),
        .RST (CHANNELS'(dcir_pkg::RST_EN))
    ) u_en (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .flg      (en_if.bank)
    );

    assign en_if.set = (wr_sel == dcir_pkg::REG_EN_SET)
                     ? reg_wdata[CHANNELS-1:0] : '0;
    assign en_if.clr = (wr_sel == dcir_pkg::REG_EN_CLR)
                     ? reg_wdata[CHANNELS-1:0] : '0;

    assign masked = raw_if.q & en_if.q;

    // a completion landing on a flag the dma has not yet consumed
    assign overrun = tx_done_pulse & raw_if.q & ~tx_done_ack;

    // sticky interrupt status, write one to clear; set wins over clear
    dcir_flag_bank #(
        .W   (IRQ_BITS),
        .RST (IRQ_BITS'(dcir_pkg::RST_IRQ_STAT))
    ) u_ist (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .flg      (ist_if.bank)
    );

    assign ist_if.set = {overrun, tx_done_pulse};
    assign ist_if.clr = (wr_sel == dcir_pkg::REG_IRQ_STAT)
                      ? reg_wdata[IRQ_BITS-1:0] : '0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_mask_ff <= IRQ_BITS'(dcir_pkg::RST_IRQ_MASK);
        end else if (wr_sel == dcir_pkg::REG_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[IRQ_BITS-1:0];
        end
    end

    // software must prime descriptors before setting this; nothing here
    // can tell whether it did
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_on_ff <= dcir_pkg::RST_RX_ON;
        end else if (wr_sel == dcir_pkg::REG_RX_CTL) begin
            rx_on_ff <= reg_wdata[dcir_pkg::RX_ON_BIT];
        end
    end

    // registered copy so the output is glitch free, one cycle behind
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            masked_ff <= '0;
        end else begin
            masked_ff <= masked;
        end
    end

    always_comb begin
        rd_value = '0;
        unique case (rd_sel)
            dcir_pkg::REG_RAW:      rd_value[CHANNELS-1:0] = raw_if.q;
            dcir_pkg::REG_MASKED:   rd_value[CHANNELS-1:0] = masked;
            dcir_pkg::REG_EN_SET:   rd_value[CHANNELS-1:0] = en_if.q;
            dcir_pkg::REG_EN_CLR:   rd_value[CHANNELS-1:0] = en_if.q;
            dcir_pkg::REG_RX_CTL:   rd_value[dcir_pkg::RX_ON_BIT] = rx_on_ff;
            dcir_pkg::REG_IRQ_STAT: rd_value[IRQ_BITS-1:0] = ist_if.q;
            dcir_pkg::REG_IRQ_MASK: rd_value[IRQ_BITS-1:0] = irq_mask_ff;
            dcir_pkg::REG_NONE:     rd_value = '0;
        endcase
    end

    // read data stand only in the cycle after the read strobe
    assign nxt_rdata = reg_rd ? rd_value : dcir_pkg::RST_RDATA;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_ff <= dcir_pkg::RST_RDATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata      = rdata_ff;
    assign tx_done_masked = masked_ff;
    assign rx_dma_on      = rx_on_ff;
    assign irq            = |(ist_if.q & irq_mask_ff);

endmodule

`default_nettype wire

//--- verif/dcir_top_properties.sv
// dcir_props: port checks of the completion flag and enable registers.
// assumes binding to dcir_top; sees only its ports.
`default_nettype none
module dcir_props #(
    parameter int CHANNELS = dcir_pkg::CHANNELS,
    parameter int ADDR_W   = dcir_pkg::ADDR_W
) (
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    input wire logic [CHANNELS-1:0] tx_done_pulse,
    input wire logic [CHANNELS-1:0] tx_done_ack,
    input wire logic [CHANNELS-1:0] tx_done_masked,
    input wire logic                rx_dma_on,
    input wire logic                irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_raw_sets: assert property (
        tx_done_pulse != '0 ##1 reg_rd && reg_addr == dcir_pkg::OFS_RAW
        |=> (reg_rdata[CHANNELS-1:0] & $past(tx_done_pulse, 2))
            == $past(tx_done_pulse, 2)) else $error("raw flag not set");
    chk_raw_upper: assert property (
        reg_rd && reg_addr == dcir_pkg::OFS_RAW
        |=> reg_rdata[31:CHANNELS] == '0) else $error("raw upper bits set");
    chk_reset_zero: assert property (
        $rose(rst_n) |-> tx_done_masked == '0 && !rx_dma_on)
        else $error("outputs not zero after reset");
    chk_en_clear: assert property (
        reg_wr && reg_addr == dcir_pkg::OFS_EN_CLR
        ##1 reg_rd && (reg_addr == dcir_pkg::OFS_EN_SET
                       || reg_addr == dcir_pkg::OFS_EN_CLR)
        |=> (reg_rdata[3:0] & $past(reg_wdata[3:0], 2)) == 4'h0)
        else $error("enable not cleared");
    chk_en_set: assert property (
        reg_wr && reg_addr == dcir_pkg::OFS_EN_SET
        ##1 reg_rd && reg_addr == dcir_pkg::OFS_EN_SET
        |=> (reg_rdata[3:0] & $past(reg_wdata[3:0], 2))
            == $past(reg_wdata[3:0], 2)) else $error("enable not set");
    chk_rx_write: assert property (
        reg_wr && reg_addr == dcir_pkg::OFS_RX_CTL
        |=> rx_dma_on == $past(reg_wdata[0])) else $error("rx enable wrong");
    chk_rx_hold: assert property (
        !(reg_wr && reg_addr == dcir_pkg::OFS_RX_CTL) |=> $stable(rx_dma_on))
        else $error("rx enable moved");
    chk_masked_and: assert property (
        reg_rd && reg_addr == dcir_pkg::OFS_MASKED
        |=> reg_rdata[CHANNELS-1:0] == tx_done_masked)
        else $error("masked status mismatch");
    cov_pulse_read: cover property (tx_done_pulse != '0 ##1 reg_rd);
    cov_en_clear: cover property (reg_wr && reg_addr == dcir_pkg::OFS_EN_CLR);
    cov_irq: cover property (irq ##1 !irq);
endmodule
bind dcir_top dcir_props #(.CHANNELS(CHANNELS), .ADDR_W(ADDR_W)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_done_pulse(tx_done_pulse),
    .tx_done_ack(tx_done_ack), .tx_done_masked(tx_done_masked),
    .rx_dma_on(rx_dma_on), .irq(irq));
`default_nettype wire

//--- verif/dcir_top_tb.sv
// dcir_top_tb: self-checking bench for the completion irq registers.
// assumes the checker is bound in from its own file.
`default_nettype none
module dcir_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic W = 1'b1;
    localparam logic R = 1'b0;
    logic        core_clk, rst_n, reg_wr, reg_rd, rx_dma_on, irq, rd_q;
    logic [7:0]  reg_addr, ist;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [3:0]  tx_done_pulse, tx_done_ack, tx_done_masked, en, raw;
    logic [31:0] exp_q[$];
    int          err_total, checks, cyc, seed;
    dcir_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_done_pulse(tx_done_pulse),
        .tx_done_ack(tx_done_ack), .tx_done_masked(tx_done_masked),
        .rx_dma_on(rx_dma_on), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one op per edge, so strobes may run back to back
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
        {tx_done_pulse, tx_done_ack} <= 8'h00;
        if (!w) exp_q.push_back(v);
    endtask
    task automatic ev(input logic [3:0] p, input logic [3:0] k);
        @(posedge core_clk);
        {reg_wr, reg_rd, tx_done_pulse, tx_done_ack} <= {2'b00, p, k};
    endtask
    // sel 0 irq, 1 rx enable, 2 masked status; read once the edge settled
    task automatic chk_port(input int sel, input logic [31:0] want);
        logic [31:0] got;
        ev(4'h0, 4'h0);
        @(negedge core_clk);
        got = (sel == 0) ? 32'(irq)
            : (sel == 1) ? 32'(rx_dma_on) : 32'(tx_done_masked);
        cmp(got, want);
    endtask
    always @(posedge core_clk) rd_q <= reg_rd;
    always @(negedge core_clk) if (rd_q) cmp(reg_rdata, exp_q.pop_front());
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {tx_done_pulse, tx_done_ack, en, raw, ist} = '0;
        seed = 71882;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        // every offset plus unmapped 0x1c and 0x20 must read zero
        for (int a = 0; a < 36; a += 4) bus(R, 8'(a), 32'h0);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            bus(W, dcir_pkg::OFS_EN_SET, d);
            en = en | d[3:0];
            bus(R, dcir_pkg::OFS_EN_SET, {28'h0, en});
            d = $random(seed);
            bus(W, dcir_pkg::OFS_EN_CLR, d);
            en = en & ~d[3:0];
            bus(R, dcir_pkg::OFS_EN_CLR, {28'h0, en});
        end
        bus(W, dcir_pkg::OFS_EN_SET, 32'h5);
        en = en | 4'h5;
        bus(W, dcir_pkg::OFS_IRQ_MASK, 32'hff);
        $display("enable set and clear done");
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            ev(d[3:0], d[7:4]);
            ist = ist | {d[3:0] & raw & ~d[7:4], d[3:0]};
            raw = (raw & ~d[7:4]) | d[3:0];
            bus(R, dcir_pkg::OFS_RAW, {28'h0, raw});
            chk_port(0, 32'(ist != 8'h00));
            bus(W, dcir_pkg::OFS_RAW, 32'hffff_ffff);
            bus(R, dcir_pkg::OFS_RAW, {28'h0, raw});
            bus(R, dcir_pkg::OFS_MASKED, {28'h0, raw & en});
            chk_port(2, {28'h0, raw & en});
        end
        bus(R, dcir_pkg::OFS_IRQ_STAT, {24'h0, ist});
        bus(W, dcir_pkg::OFS_IRQ_MASK, 32'h0);
        chk_port(0, 32'h0);
        bus(W, dcir_pkg::OFS_IRQ_MASK, 32'hff);
        bus(W, dcir_pkg::OFS_IRQ_STAT, 32'hff);
        chk_port(0, 32'h0);
        $display("completion events done");
        // receive chain taken as primed here, so the enable may follow
        bus(W, dcir_pkg::OFS_RX_CTL, 32'hffff_ffff);
        bus(R, dcir_pkg::OFS_RX_CTL, 32'h1);
        chk_port(1, 32'h1);
        bus(W, dcir_pkg::OFS_RX_CTL, 32'hffff_fffe);
        bus(R, dcir_pkg::OFS_RX_CTL, 32'h0);
        chk_port(1, 32'h0);
        $display("receive enable done");
        repeat (3) @(posedge core_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
